// [hvm_host.sv]
// Purpose: Host that writes and reads the control registers.
// Assumes: AXI4-Lite slave on the far side.
// Notes: A wait that runs out raises hang_out.
module hvm_host
(
   input wire logic clock_in,
   output logic awv_out,
   output logic [7:0] awa_out,
   output logic wv_out,
   output logic [31:0] wd_out,
   output logic [3:0] ws_out,
   output logic br_out,
   output logic arv_out,
   output logic [7:0] ara_out,
   output logic rr_out,
   input wire logic awr_in,
   input wire logic wr_in,
   input wire logic bv_in,
   input wire logic [1:0] bx_in,
   input wire logic arr_in,
   input wire logic rv_in,
   input wire logic [31:0] rd_in,
   input wire logic [1:0] rx_in,
   output logic hang_out
);
   timeunit 1ns / 1ps;
   initial
   begin
      {awv_out, wv_out, br_out, arv_out, rr_out, hang_out} = 6'h00;
      {awa_out, ara_out, wd_out} = 48'h0;
      ws_out = 4'hF;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic tw;
      logic done;
      int n;
      done = 1'b0;
      @(posedge clock_in);
      awv_out <= 1'b1;
      awa_out <= a;
      wv_out <= 1'b1;
      wd_out <= d;
      br_out <= 1'b1;
      for (n = 0; n < 40 && !done; n++)
      begin
         @(negedge clock_in);
         ta = awv_out && awr_in;
         tw = wv_out && wr_in;
         done = bv_in;
         r = bx_in;
         @(posedge clock_in);
         awv_out <= awv_out && !ta;
         wv_out <= wv_out && !tw;
         br_out <= !done;
      end
      hang_out = hang_out || !done;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta;
      logic done;
      int n;
      done = 1'b0;
      @(posedge clock_in);
      arv_out <= 1'b1;
      ara_out <= a;
      rr_out <= 1'b1;
      for (n = 0; n < 40 && !done; n++)
      begin
         @(negedge clock_in);
         ta = arv_out && arr_in;
         done = rv_in;
         d = rd_in;
         r = rx_in;
         @(posedge clock_in);
         arv_out <= arv_out && !ta;
         rr_out <= !done;
      end
      hang_out = hang_out || !done;
   endtask : rd_reg
endmodule : hvm_host

// [hvm_irq.sv]
// Purpose: Sticky interrupt status, mask and one level interrupt.
// Assumes: Write strobes last one cycle.
// Notes: A set in the clearing cycle wins.
module hvm_irq
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic [1:0] event_in,
   input wire logic stat_wr_in,
   input wire logic mask_wr_in,
   input wire logic [1:0] wdata_in,
   output logic [1:0] stat_out,
   output logic [1:0] mask_out,
   output logic irq_out
);
   logic [1:0] stat_q, stat_d, mask_q, mask_d;
   logic irq_q, irq_d;
   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      stat_d = (stat_q & ~(stat_wr_in ? wdata_in : 2'h0)) | event_in;
      mask_d = mask_wr_in ? wdata_in : mask_q;
      irq_d = |(stat_d & mask_d);
   end
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         stat_q <= 2'h0;
         mask_q <= 2'h0;
         irq_q <= 1'b0;
      end
      else
      begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q <= irq_d;
      end
   end
   assign stat_out = stat_q;
   assign mask_out = mask_q;
   assign irq_out = irq_q;
endmodule : hvm_irq

// [hvm_map.svh]
// Purpose: Register offsets, field positions, reset values and codes.
// Assumes: Byte addresses on an 8-bit AXI4-Lite address.
// Notes: Definitions only.
`ifndef HVM_MAP_SVH
`define HVM_MAP_SVH
// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define HVM_CTRL_OFS 8'h00
`define HVM_WKC1_OFS 8'h04
`define HVM_PULL_OFS 8'h08
`define HVM_GPIO_OFS 8'h0C
`define HVM_MODE_OFS 8'h10
`define HVM_WST0_OFS 8'h14
`define HVM_WST1_OFS 8'h18
`define HVM_WLVL_OFS 8'h1C
`define HVM_IST_OFS 8'h20
`define HVM_IMSK_OFS 8'h24
// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define HVM_CTRL_MEAS_BIT 0
`define HVM_CTRL_FOT_BIT 1
`define HVM_WKC1_SENSE_BIT 0
`define HVM_WKC1_OTHER_BIT 2
`define HVM_GPIO_ON_BIT 3
`define HVM_IST_FAULT_BIT 0
`define HVM_IST_WAKE_BIT 1
// ---------------------------------------------------------------
// Reset values and codes
// ---------------------------------------------------------------
`define HVM_CTRL_RST 2'h0
`define HVM_WKC1_RST 3'h0
`define HVM_PULL_RST 4'h0
`define HVM_GPIO_RST 4'h0
`define HVM_CMD_NORMAL 3'h0
`define HVM_CMD_STOP 3'h1
`define HVM_CMD_SLEEP 3'h2
`define HVM_RESP_OKAY 2'h0
`define HVM_RESP_SLVERR 2'h2
`endif

// [hvm_pin_gate.sv]
// Purpose: Pull, level and wake handling of one sense-capable pin.
// Assumes: Pin input synchronous to the clock.
// Notes: While gated the level is frozen and no wake is reported.
module hvm_pin_gate
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic pin_in,
   input wire logic gate_in,
   input wire logic wake_en_in,
   input wire logic [1:0] pull_cfg_in,
   output logic level_out,
   output logic wake_out,
   output logic pull_up_out,
   output logic pull_dn_out
);
   logic level_q, level_d, wake_q, wake_d, pu_q, pu_d, pd_q, pd_d;
   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb
   begin
      level_d = gate_in ? level_q : pin_in; // see (R6) see (R7)
      wake_d = !gate_in && wake_en_in && (pin_in != level_q); // see (R9)
      pu_d = !gate_in && pull_cfg_in[0]; // see (R4) see (R5)
      pd_d = !gate_in && pull_cfg_in[1]; // see (R4)
   end
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         level_q <= 1'b0;
         wake_q <= 1'b0;
         pu_q <= 1'b0;
         pd_q <= 1'b0;
      end
      else
      begin
         level_q <= level_d;
         wake_q <= wake_d;
         pu_q <= pu_d;
         pd_q <= pd_d;
      end
   end
   assign level_out = level_q;
   assign wake_out = wake_q;
   assign pull_up_out = pu_q;
   assign pull_dn_out = pd_q;
endmodule : hvm_pin_gate

// [hvm_pkg.sv]
// Purpose: Types shared by the measurement switch control files.
// Assumes: Nothing beyond the map header.
// Notes: Codes are one-hot for the operating modes.
package hvm_pkg;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [4:0]
   {
      HVM_NORMAL = 5'h01,
      HVM_STOP = 5'h02,
      HVM_SLEEP = 5'h04,
      HVM_RESTART = 5'h08,
      HVM_FAILSAFE = 5'h10
   } hvm_mode_t;
   typedef enum logic [2:0]
   {
      HVM_GPIO_OFF = 3'h0,
      HVM_GPIO_FAIL = 3'h1,
      HVM_GPIO_WAKE = 3'h2,
      HVM_GPIO_LS = 3'h3,
      HVM_GPIO_HS = 3'h4
   } hvm_gpio_mode_t;
endpackage : hvm_pkg

// [hvm_top.sv]
// Purpose: High-voltage measurement switch control with AXI4-Lite registers.
// Assumes: Pins and fail_safe_in synchronous to clock_in.
// Notes: Operating mode is tracked here and shown on mode_out.
// Operation
// (R1) Reset: measurement off, switch open, defaults.
// (R2) Switch closes only in normal mode.
// (R3) Enable kept when leaving normal mode.
// (R4) Pulls off, pin inputs gated while measuring.
// (R5) Pull, wake, GPIO settings ignored, still writable.
// (R6) Wake and level status frozen while measuring.
// (R7) Disabled: normal wake and level updates.
// (R8) Sleep with only pin wakes: fault, restart.
// (R9) Wake enables writable but without effect.
// (R10) Fail output, test, GPIO unavailable while measuring.
// (R11) GPIO config change while measuring: fault.
// (R12) Enable refused with fault unless GPIO off.
// (R13) Fail-safe keeps enable, opens switch.
// (R14) Fail-safe without measurement enables sense wake.
// (R15) Switch equals enable AND normal mode.
`include "hvm_map.svh"
module hvm_top
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic axi_awvalid_in,
   output logic axi_awready_out,
   input wire logic [7:0] axi_awaddr_in,
   input wire logic axi_wvalid_in,
   output logic axi_wready_out,
   input wire logic [31:0] axi_wdata_in,
   input wire logic [3:0] axi_wstrb_in,
   output logic axi_bvalid_out,
   input wire logic axi_bready_in,
   output logic [1:0] axi_bresp_out,
   input wire logic axi_arvalid_in,
   output logic axi_arready_out,
   input wire logic [7:0] axi_araddr_in,
   output logic axi_rvalid_out,
   input wire logic axi_rready_in,
   output logic [31:0] axi_rdata_out,
   output logic [1:0] axi_rresp_out,
   input wire logic sense_pin_in,
   input wire logic gpio_pin_in,
   input wire logic fail_safe_in,
   output logic meas_switch_out,
   output logic sense_pull_up_out,
   output logic sense_pull_dn_out,
   output logic gpio_pull_up_out,
   output logic gpio_pull_dn_out,
   output logic gpio_pin_out,
   output logic gpio_pin_oe_out,
   output logic [4:0] mode_out,
   output logic irq_out
);
   hvm_pkg::hvm_mode_t mode_q, mode_d;
   logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [7:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic wstrb0_q, wstrb0_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic [1:0] ctrl_q, ctrl_d;
   logic [2:0] wkc_q, wkc_d;
   logic [3:0] pull_q, pull_d, gcfg_q, gcfg_d;
   logic wst0_q, wst0_d, wst1_q, wst1_d;
   logic sw_q, sw_d, goe_q, goe_d, gout_q, gout_d;
   logic [2:0] rdy_q, rdy_d;
   logic wr, wr_en, fault, meas, ist_wr, imsk_wr, ar_take;
   logic s_lvl, s_wake, g_lvl, g_wake;
   logic [1:0] ist, imsk;
   hvm_pkg::hvm_gpio_mode_t gmode;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a <= `HVM_IMSK_OFS) && (a[1:0] == 2'h0);
   endfunction : mapped

   assign meas = ctrl_q[`HVM_CTRL_MEAS_BIT];
   assign gmode = hvm_pkg::hvm_gpio_mode_t'(gcfg_q[2:0]);
   // ---------------------------------------------------------------
   // Pin handling
   // ---------------------------------------------------------------
   hvm_pin_gate u_sense
   (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .pin_in(sense_pin_in),
      .gate_in(meas),
      .wake_en_in(wkc_q[`HVM_WKC1_SENSE_BIT]),
      .pull_cfg_in(pull_q[1:0]),
      .level_out(s_lvl),
      .wake_out(s_wake),
      .pull_up_out(sense_pull_up_out),
      .pull_dn_out(sense_pull_dn_out)
   );
   hvm_pin_gate u_gpio
   (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .pin_in(gpio_pin_in),
      .gate_in(meas),
      .wake_en_in(gmode == hvm_pkg::HVM_GPIO_WAKE),
      .pull_cfg_in(pull_q[3:2]),
      .level_out(g_lvl),
      .wake_out(g_wake),
      .pull_up_out(gpio_pull_up_out),
      .pull_dn_out(gpio_pull_dn_out)
   );
   // ---------------------------------------------------------------
   // Interrupts
   // ---------------------------------------------------------------
   assign ist_wr = wr_en && (awaddr_q == `HVM_IST_OFS);
   assign imsk_wr = wr_en && (awaddr_q == `HVM_IMSK_OFS);
   hvm_irq u_irq
   (
      .clock_in(clock_in),
      .arst_n_in(arst_n_in),
      .event_in({s_wake | g_wake, fault}),
      .stat_wr_in(ist_wr),
      .mask_wr_in(imsk_wr),
      .wdata_in(wdata_q[1:0]),
      .stat_out(ist),
      .mask_out(imsk),
      .irq_out(irq_out)
   );
   // ---------------------------------------------------------------
   // Bus handshake
   // ---------------------------------------------------------------
   always_comb
   begin
      aw_d = aw_q;
      w_d = w_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb0_d = wstrb0_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      wr = aw_q && w_q && !bvalid_q;
      wr_en = wr && wstrb0_q && mapped(awaddr_q);
      if (axi_awvalid_in && !aw_q && !bvalid_q)
      begin
         aw_d = 1'b1;
         awaddr_d = axi_awaddr_in;
      end
      if (axi_wvalid_in && !w_q && !bvalid_q)
      begin
         w_d = 1'b1;
         wdata_d = axi_wdata_in;
         wstrb0_d = axi_wstrb_in[0];
      end
      if (wr)
      begin
         aw_d = 1'b0;
         w_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = mapped(awaddr_q) ? `HVM_RESP_OKAY : `HVM_RESP_SLVERR;
      end
      if (bvalid_q && axi_bready_in)
      begin
         bvalid_d = 1'b0;
      end
      ar_take = axi_arvalid_in && !rvalid_q;
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (ar_take)
      begin
         rvalid_d = 1'b1;
         rresp_d = mapped(axi_araddr_in) ? `HVM_RESP_OKAY : `HVM_RESP_SLVERR;
         case (axi_araddr_in)
            `HVM_CTRL_OFS: rdata_d = {30'h0, ctrl_q};
            `HVM_WKC1_OFS: rdata_d = {29'h0, wkc_q};
            `HVM_PULL_OFS: rdata_d = {28'h0, pull_q};
            `HVM_GPIO_OFS: rdata_d = {28'h0, gcfg_q};
            `HVM_MODE_OFS: rdata_d = {27'h0, mode_q};
            `HVM_WST0_OFS: rdata_d = {31'h0, wst0_q};
            `HVM_WST1_OFS: rdata_d = {31'h0, wst1_q};
            `HVM_WLVL_OFS: rdata_d = {30'h0, g_lvl, s_lvl};
            `HVM_IST_OFS: rdata_d = {30'h0, ist};
            `HVM_IMSK_OFS: rdata_d = {30'h0, imsk};
            default: rdata_d = 32'h0;
         endcase
      end
      else if (rvalid_q && axi_rready_in)
      begin
         rvalid_d = 1'b0;
      end
      rdy_d = {!aw_d && !bvalid_d, !w_d && !bvalid_d, !rvalid_d};
   end
   // ---------------------------------------------------------------
   // Configuration, mode and pin drive
   // ---------------------------------------------------------------
   always_comb
   begin
      ctrl_d = ctrl_q;
      wkc_d = wkc_q;
      pull_d = pull_q;
      gcfg_d = gcfg_q;
      mode_d = mode_q;
      fault = 1'b0;
      wst0_d = wst0_q | s_wake; // see (R7)
      wst1_d = wst1_q | g_wake; // see (R6)
      if (wr_en)
      begin
         case (awaddr_q)
            `HVM_CTRL_OFS:
            begin
               fault = wdata_q[0] && !meas && (gmode != hvm_pkg::HVM_GPIO_OFF); // see (R12)
               ctrl_d = {wdata_q[1], wdata_q[0] && !fault};
            end
            `HVM_WKC1_OFS: wkc_d = wdata_q[2:0]; // see (R9)
            `HVM_PULL_OFS: pull_d = wdata_q[3:0]; // see (R5)
            `HVM_GPIO_OFS:
            begin
               gcfg_d = wdata_q[3:0]; // see (R5)
               fault = meas && (wdata_q[3:0] != gcfg_q); // see (R11)
            end
            `HVM_MODE_OFS:
            begin
               if ((mode_q == hvm_pkg::HVM_NORMAL) && (wdata_q[2:0] == `HVM_CMD_STOP))
                  mode_d = hvm_pkg::HVM_STOP;
               else if ((mode_q == hvm_pkg::HVM_NORMAL) && (wdata_q[2:0] == `HVM_CMD_SLEEP))
               begin
                  fault = meas && !wkc_q[`HVM_WKC1_OTHER_BIT]; // see (R8)
                  mode_d = fault ? hvm_pkg::HVM_RESTART : hvm_pkg::HVM_SLEEP;
               end
               else if ((mode_q == hvm_pkg::HVM_STOP) && (wdata_q[2:0] == `HVM_CMD_NORMAL))
                  mode_d = hvm_pkg::HVM_NORMAL;
            end
            `HVM_WST0_OFS: wst0_d = (wst0_q & ~wdata_q[0]) | s_wake;
            `HVM_WST1_OFS: wst1_d = (wst1_q & ~wdata_q[0]) | g_wake;
            default: fault = 1'b0;
         endcase
      end
      case (mode_q)
         hvm_pkg::HVM_RESTART: mode_d = hvm_pkg::HVM_NORMAL;
         hvm_pkg::HVM_SLEEP,
         hvm_pkg::HVM_FAILSAFE:
         begin
            if (s_wake || g_wake)
            begin
               mode_d = hvm_pkg::HVM_RESTART;
            end
         end
         default: mode_d = mode_d;
      endcase
      if (fail_safe_in && (mode_q != hvm_pkg::HVM_FAILSAFE))
      begin
         mode_d = hvm_pkg::HVM_FAILSAFE; // see (R13)
         if (!ctrl_d[`HVM_CTRL_MEAS_BIT])
         begin
            wkc_d[`HVM_WKC1_SENSE_BIT] = 1'b1; // see (R14)
         end
      end
      // Enable is kept across modes; the switch follows the mode.
      sw_d = ctrl_d[`HVM_CTRL_MEAS_BIT] && (mode_d == hvm_pkg::HVM_NORMAL); // see (R2) see (R3) see (R15)
      goe_d = 1'b0;
      gout_d = 1'b0;
      if (!ctrl_d[`HVM_CTRL_MEAS_BIT]) // see (R10)
      begin
         case (hvm_pkg::hvm_gpio_mode_t'(gcfg_d[2:0]))
            hvm_pkg::HVM_GPIO_FAIL: goe_d = (mode_d == hvm_pkg::HVM_FAILSAFE) ||
                                            ctrl_d[`HVM_CTRL_FOT_BIT];
            hvm_pkg::HVM_GPIO_LS: goe_d = gcfg_d[`HVM_GPIO_ON_BIT];
            hvm_pkg::HVM_GPIO_HS:
            begin
               goe_d = gcfg_d[`HVM_GPIO_ON_BIT];
               gout_d = 1'b1;
            end
            default: goe_d = 1'b0;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `HVM_RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= `HVM_RESP_OKAY;
         rdy_q <= 3'h7;
         ctrl_q <= `HVM_CTRL_RST; // see (R1)
         wkc_q <= `HVM_WKC1_RST;
         pull_q <= `HVM_PULL_RST;
         gcfg_q <= `HVM_GPIO_RST;
         mode_q <= hvm_pkg::HVM_NORMAL;
         wst0_q <= 1'b0;
         wst1_q <= 1'b0;
         sw_q <= 1'b0; // see (R1)
         goe_q <= 1'b0;
         gout_q <= 1'b0;
      end
      else
      begin
         aw_q <= aw_d;
         w_q <= w_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb0_q <= wstrb0_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         rdy_q <= rdy_d;
         ctrl_q <= ctrl_d;
         wkc_q <= wkc_d;
         pull_q <= pull_d;
         gcfg_q <= gcfg_d;
         mode_q <= mode_d;
         wst0_q <= wst0_d;
         wst1_q <= wst1_d;
         sw_q <= sw_d;
         goe_q <= goe_d;
         gout_q <= gout_d;
      end
   end
   assign axi_awready_out = rdy_q[2];
   assign axi_wready_out = rdy_q[1];
   assign axi_bvalid_out = bvalid_q;
   assign axi_bresp_out = bresp_q;
   assign axi_arready_out = rdy_q[0];
   assign axi_rvalid_out = rvalid_q;
   assign axi_rdata_out = rdata_q;
   assign axi_rresp_out = rresp_q;
   assign meas_switch_out = sw_q;
   assign gpio_pin_out = gout_q;
   assign gpio_pin_oe_out = goe_q;
   assign mode_out = mode_q;
endmodule : hvm_top

// [hvm_top_assertions.sv]
// Purpose: Port checks of the measurement switch control.
// Assumes: One-hot mode codes on mode_out.
// Notes: Bound to hvm_top after the module.
module hvm_top_checker
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic axi_bvalid_out,
   input wire logic fail_safe_in,
   input wire logic meas_switch_out,
   input wire logic sense_pull_up_out,
   input wire logic sense_pull_dn_out,
   input wire logic gpio_pull_up_out,
   input wire logic gpio_pull_dn_out,
   input wire logic gpio_pin_oe_out,
   input wire logic [4:0] mode_out
);
   timeunit 1ns / 1ps;
   default clocking ck @(posedge clock_in);
   endclocking
   default disable iff (!arst_n_in);
   // ----------
   // Assertions and covers
   // ----------
   a_reset_open: assert property (
      !$past(arst_n_in) |-> !meas_switch_out && mode_out == 5'h01)
      else $error("Switch or mode wrong after reset.");
   a_switch_normal: assert property (
      meas_switch_out |-> mode_out == 5'h01)
      else $error("Switch closed outside normal mode.");
   a_failsafe_open: assert property (
      mode_out == 5'h10 |-> !meas_switch_out)
      else $error("Switch closed in fail-safe mode.");
   a_pulls_off: assert property (
      meas_switch_out && $past(meas_switch_out) |-> !(sense_pull_up_out ||
      sense_pull_dn_out || gpio_pull_up_out || gpio_pull_dn_out))
      else $error("Pull enabled while measuring.");
   a_gpio_quiet: assert property (
      meas_switch_out && $past(meas_switch_out) |-> !gpio_pin_oe_out)
      else $error("Shared pin driven while measuring.");
   a_restart_short: assert property (
      mode_out == 5'h08 |=> mode_out == 5'h01)
      else $error("Restart did not return to normal.");
   a_failsafe_entry: assert property (
      fail_safe_in && mode_out != 5'h10 |=> mode_out == 5'h10)
      else $error("Fail-safe mode not entered.");
   a_close_cause: assert property (
      $rose(meas_switch_out) |-> $rose(axi_bvalid_out) ||
      $past(mode_out) != 5'h01 || $past(mode_out, 2) != 5'h01)
      else $error("Switch closed without write or mode change.");
   c_closed: cover property (meas_switch_out && $past(meas_switch_out));
   c_restart: cover property (mode_out == 5'h08);
   c_failsafe: cover property (mode_out == 5'h10);
endmodule : hvm_top_checker
bind hvm_top hvm_top_checker hvm_top_checker_inst
(
   .clock_in(clock_in), .arst_n_in(arst_n_in), .axi_bvalid_out(axi_bvalid_out),
   .fail_safe_in(fail_safe_in), .meas_switch_out(meas_switch_out),
   .sense_pull_up_out(sense_pull_up_out), .sense_pull_dn_out(sense_pull_dn_out),
   .gpio_pull_up_out(gpio_pull_up_out), .gpio_pull_dn_out(gpio_pull_dn_out),
   .gpio_pin_oe_out(gpio_pin_oe_out), .mode_out(mode_out)
);

// [hvm_top_tb.sv]
// Purpose: Self-checking bench of the measurement switch control.
// Assumes: Host model drives the register bus.
// Notes: Ends through test_done.
`include "hvm_map.svh"
module hvm_top_tb;
   timeunit 1ns / 1ps;
   logic clock_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic sense_pin_in = 1'b0;
   logic gpio_pin_in = 1'b0;
   logic fail_safe_in = 1'b0;
   logic saw_restart = 1'b0;
   logic aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r, hang;
   logic sw, su, sd, gu, gd, go, goe, irq;
   logic [7:0] aw_a, ar_a;
   logic [31:0] w_d, r_d;
   logic [3:0] w_s;
   logic [1:0] b_x, r_x;
   logic [4:0] mode;
   int bad_count = 0;
   int compares = 0;
   always #5 clock_in = ~clock_in;
   hvm_top hvm_top_inst
   (
      .clock_in(clock_in), .arst_n_in(arst_n_in), .axi_awvalid_in(aw_v),
      .axi_awready_out(aw_r), .axi_awaddr_in(aw_a), .axi_wvalid_in(w_v),
      .axi_wready_out(w_r), .axi_wdata_in(w_d), .axi_wstrb_in(w_s), .axi_bvalid_out(b_v),
      .axi_bready_in(b_r), .axi_bresp_out(b_x), .axi_arvalid_in(ar_v),
      .axi_arready_out(ar_r), .axi_araddr_in(ar_a), .axi_rvalid_out(r_v),
      .axi_rready_in(r_r), .axi_rdata_out(r_d), .axi_rresp_out(r_x),
      .sense_pin_in(sense_pin_in), .gpio_pin_in(gpio_pin_in), .fail_safe_in(fail_safe_in),
      .meas_switch_out(sw), .sense_pull_up_out(su), .sense_pull_dn_out(sd),
      .gpio_pull_up_out(gu), .gpio_pull_dn_out(gd), .gpio_pin_out(go),
      .gpio_pin_oe_out(goe), .mode_out(mode), .irq_out(irq)
   );
   hvm_host hvm_host_inst
   (
      .clock_in(clock_in), .awv_out(aw_v), .awa_out(aw_a), .wv_out(w_v), .wd_out(w_d),
      .ws_out(w_s), .br_out(b_r), .arv_out(ar_v), .ara_out(ar_a), .rr_out(r_r),
      .awr_in(aw_r), .wr_in(w_r), .bv_in(b_v), .bx_in(b_x), .arr_in(ar_r), .rv_in(r_v),
      .rd_in(r_d), .rx_in(r_x), .hang_out(hang)
   );
   always @(posedge clock_in)
   begin
      if (mode === 5'h08)
         saw_restart <= 1'b1;
   end
   task automatic test_done();
      $display("Compares %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : test_done
   always @(posedge hang)
   begin
      bad_count++;
      test_done();
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = `HVM_RESP_OKAY);
      logic [1:0] r;
      hvm_host_inst.wr_reg(a, d, r);
      check(r, er);
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
      input logic [1:0] er = `HVM_RESP_OKAY);
      logic [31:0] d;
      logic [1:0] r;
      hvm_host_inst.rd_reg(a, d, r);
      check(d, e);
      check(r, er);
   endtask : rd_chk
   task automatic settle(input int n);
      repeat (n) @(posedge clock_in);
      @(negedge clock_in);
   endtask : settle
   task automatic drive(input logic s, input logic g, input logic f);
      @(posedge clock_in);
      sense_pin_in <= s;
      gpio_pin_in <= g;
      fail_safe_in <= f;
   endtask : drive
   task automatic do_reset();
      @(posedge clock_in);
      arst_n_in <= 1'b0;
      repeat (5) @(posedge clock_in);
      arst_n_in <= 1'b1;
   endtask : do_reset
   task automatic t_reset();
      settle(0);
      check({sw, mode}, 6'h01);
      rd_chk(`HVM_CTRL_OFS, 32'h0);
      rd_chk(8'h28, 32'h0, `HVM_RESP_SLVERR);
      wr(8'h28, 32'h1, `HVM_RESP_SLVERR);
   endtask : t_reset
   task automatic t_refuse();
      wr(`HVM_IMSK_OFS, 32'h0);
      wr(`HVM_GPIO_OFS, 32'h1);
      wr(`HVM_CTRL_OFS, 32'h3);
      settle(2);
      check({sw, irq, goe, go}, 4'h2);
      rd_chk(`HVM_CTRL_OFS, 32'h2);
      rd_chk(`HVM_IST_OFS, 32'h1);
      wr(`HVM_IMSK_OFS, 32'h3);
      settle(2);
      check(irq, 1'b1);
      wr(`HVM_IST_OFS, 32'h1);
      wr(`HVM_GPIO_OFS, 32'hC);
      settle(1);
      check({goe, go, irq}, 3'h6);
      wr(`HVM_GPIO_OFS, 32'h0);
   endtask : t_refuse
   task automatic t_measure();
      wr(`HVM_PULL_OFS, 32'hF);
      wr(`HVM_WKC1_OFS, 32'h1);
      settle(2);
      check({su, sd, gu, gd}, 4'hF);
      wr(`HVM_CTRL_OFS, 32'h1);
      settle(2);
      check({sw, su, sd, gu, gd}, 5'h10);
      wr(`HVM_GPIO_OFS, 32'hC);
      wr(`HVM_CTRL_OFS, 32'h3);
      settle(1);
      check(goe, 1'b0);
      rd_chk(`HVM_GPIO_OFS, 32'hC);
      rd_chk(`HVM_IST_OFS, 32'h1);
      wr(`HVM_IST_OFS, 32'h1);
      drive(1'b1, 1'b1, 1'b0);
      settle(5);
      rd_chk(`HVM_WST0_OFS, 32'h0);
      rd_chk(`HVM_WLVL_OFS, 32'h0);
      drive(1'b0, 1'b0, 1'b0);
   endtask : t_measure
   task automatic t_modes();
      wr(`HVM_MODE_OFS, 32'h1);
      settle(1);
      check({sw, mode}, 6'h02);
      rd_chk(`HVM_CTRL_OFS, 32'h3);
      wr(`HVM_MODE_OFS, 32'h0);
      settle(1);
      check({sw, mode}, 6'h21);
      wr(`HVM_MODE_OFS, 32'h2);
      settle(1);
      check({saw_restart, sw, mode}, 7'h61);
      rd_chk(`HVM_IST_OFS, 32'h1);
      wr(`HVM_IST_OFS, 32'h1);
   endtask : t_modes
   task automatic t_failsafe_meas();
      wr(`HVM_WKC1_OFS, 32'h0);
      drive(1'b0, 1'b0, 1'b1);
      settle(2);
      check({sw, goe, mode}, 7'h10);
      rd_chk(`HVM_CTRL_OFS, 32'h3);
      rd_chk(`HVM_WKC1_OFS, 32'h0);
      drive(1'b0, 1'b0, 1'b0);
   endtask : t_failsafe_meas
   task automatic t_failsafe_off();
      wr(`HVM_IMSK_OFS, 32'h3);
      drive(1'b0, 1'b0, 1'b1);
      drive(1'b0, 1'b0, 1'b0);
      settle(1);
      check(mode, 5'h10);
      rd_chk(`HVM_WKC1_OFS, 32'h1);
      drive(1'b1, 1'b0, 1'b0);
      settle(6);
      check({irq, mode}, 6'h21);
      rd_chk(`HVM_WST0_OFS, 32'h1);
      rd_chk(`HVM_WLVL_OFS, 32'h1);
      rd_chk(`HVM_IST_OFS, 32'h2);
      wr(`HVM_MODE_OFS, 32'h2);
      settle(1);
      check(mode, 5'h04);
   endtask : t_failsafe_off
   initial
   begin
      do_reset();
      t_reset();
      t_refuse();
      t_measure();
      t_modes();
      t_failsafe_meas();
      do_reset();
      t_failsafe_off();
      test_done();
   end
endmodule : hvm_top_tb
